// ### radio_interrupt_logic.sv
// Overview of operation
// - Ten events feed eight flags; two pairs share one each.
// - Mask register at 0x0E enables each event.
// - Enabled pending flags OR onto one pin.
// - Status read at 0x0F clears flags and pin.
// - Flags stay set until a read, a register clear or the cross-clear below clears them.
// - Lock and unlock events clear each other's flag.
// - Fixed flag bit assignment, supply low on top.
// - Frame end set on receive or transmit completion.
// - Reception start flag set on payload start.
// - Unlock while transmitting switches amplifier off.
// - Shared flag: wake complete or measurement done.
// - Visibility off: only unmasked events recorded.
// - Visibility on: all recorded, pin masked still.
// - Pin active high, polarity bit inverts it.
// - Mask resets to zero, accepts any value.
// - Control bit 0 at 0x04 selects polarity.
// - Control bit 1 at 0x04 enables visibility.
`timescale 1ns/1ps
`default_nettype none
`include "radio_interrupt_params.svh"

module radio_interrupt_logic (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       reg_clear_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_wdata_in,
	output var  logic [7:0] reg_rdata_out,
	output var  logic       reg_rvalid_out,
	input  wire logic       supply_low_event_in,
	input  wire logic       buffer_access_violation_in,
	input  wire logic       address_match_event_in,
	input  wire logic       wake_complete_in,
	input  wire logic       channel_measurement_done_in,
	input  wire logic       frame_complete_rx_in,
	input  wire logic       frame_complete_tx_in,
	input  wire logic       reception_start_in,
	input  wire logic       pll_unlock_in,
	input  wire logic       pll_lock_in,
	input  wire logic       tx_busy_in,
	output var  logic       irq_out,
	output var  logic       pa_off_out
);

	// ======================================================================
	// Declarations
	radio_interrupt_pkg::reg_byte_type interrupt_enable_mask_q;
	radio_interrupt_pkg::reg_byte_type interrupt_enable_mask_d;
	logic                              active_low_q;
	logic                              active_low_d;
	logic                              visibility_q;
	logic                              visibility_d;
	radio_interrupt_pkg::reg_byte_type event_vec;
	radio_interrupt_pkg::reg_byte_type record_vec;
	radio_interrupt_pkg::reg_byte_type flags_d;
	radio_interrupt_pkg::reg_byte_type flags_q;
	logic                              status_read;
	radio_interrupt_pkg::reg_byte_type reg_rdata_q;
	logic                              reg_rvalid_q;
	radio_interrupt_pkg::pa_state_type pa_state_q;
	radio_interrupt_pkg::pa_state_type pa_state_d;
	logic                              pa_off_q;

	// ======================================================================
	// Read decode
	function automatic radio_interrupt_pkg::reg_byte_type read_mux(
		input logic [7:0]                        addr,
		input radio_interrupt_pkg::reg_byte_type mask,
		input logic                              low,
		input logic                              vis,
		input radio_interrupt_pkg::reg_byte_type flags
	);
		radio_interrupt_pkg::reg_byte_type ctrl;
		ctrl = `RESET_CONTROL_ONE;
		ctrl[`CTRL_POLARITY_BIT]   = low;
		ctrl[`CTRL_VISIBILITY_BIT] = vis;
		if (addr == `ADDR_TRANSCEIVER_CONTROL_ONE) begin
			read_mux = ctrl;
		end else if (addr == `ADDR_INTERRUPT_ENABLE_MASK) begin
			read_mux = mask;
		end else if (addr == `ADDR_INTERRUPT_FLAGS) begin
			read_mux = flags;
		end else begin
			read_mux = `READ_UNMAPPED_VALUE;
		end
	endfunction

	// ======================================================================
	// Event collection
	always_comb begin
		event_vec                          = 8'h00;
		event_vec[`FLAG_SUPPLY_LOW]        = supply_low_event_in;
		event_vec[`FLAG_BUFFER_VIOLATION]  = buffer_access_violation_in;
		event_vec[`FLAG_ADDRESS_MATCH]     = address_match_event_in;
		event_vec[`FLAG_WAKE_OR_MEASURE]   = wake_complete_in | channel_measurement_done_in;
		event_vec[`FLAG_FRAME_COMPLETE]    = frame_complete_rx_in | frame_complete_tx_in;
		event_vec[`FLAG_RECEPTION_START]   = reception_start_in;
		event_vec[`FLAG_UNLOCK]            = pll_unlock_in;
		event_vec[`FLAG_LOCK]              = pll_lock_in;
	end

	always_comb begin
		if (visibility_q) begin
			record_vec = `ALL_EVENTS_RECORDED;
		end else begin
			record_vec = interrupt_enable_mask_q;
		end
	end

	// A status read clears only when it is the status address being read.
	always_comb begin
		status_read = reg_rd_in && (reg_addr_in == `ADDR_INTERRUPT_FLAGS);
	end

	// ======================================================================
	// Writable registers
	always_comb begin
		interrupt_enable_mask_d = interrupt_enable_mask_q;
		active_low_d            = active_low_q;
		visibility_d            = visibility_q;
		if (reg_clear_in) begin
			interrupt_enable_mask_d = `RESET_INTERRUPT_ENABLE_MASK;
			active_low_d            = 1'b0;
			visibility_d            = 1'b0;
		end else if (reg_wr_in && (reg_addr_in == `ADDR_INTERRUPT_ENABLE_MASK)) begin
			interrupt_enable_mask_d = reg_wdata_in;
		end else if (reg_wr_in && (reg_addr_in == `ADDR_TRANSCEIVER_CONTROL_ONE)) begin
			active_low_d = reg_wdata_in[`CTRL_POLARITY_BIT];
			visibility_d = reg_wdata_in[`CTRL_VISIBILITY_BIT];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			interrupt_enable_mask_q <= `RESET_INTERRUPT_ENABLE_MASK;
		end else begin
			interrupt_enable_mask_q <= interrupt_enable_mask_d;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_low_q <= 1'b0;
			visibility_q <= 1'b0;
		end else begin
			active_low_q <= active_low_d;
			visibility_q <= visibility_d;
		end
	end

	// ======================================================================
	// Read data
	// The status value is captured before the clear lands on the same edge.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_q  <= `READ_UNMAPPED_VALUE;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd_in;
			if (reg_rd_in) begin
				reg_rdata_q <= read_mux(reg_addr_in, interrupt_enable_mask_q, active_low_q, visibility_q, flags_q);
			end
		end
	end

	// ======================================================================
	// Flags and pin
	event_flag_bank u_flags (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.clear_all_in  (reg_clear_in),
		.read_clear_in (status_read),
		.event_in      (event_vec),
		.record_in     (record_vec),
		.flags_d_out   (flags_d),
		.flags_q_out   (flags_q)
	);

	irq_pin_driver u_pin (
		.clk_in          (clk_in),
		.rst_n_in        (rst_n_in),
		.flags_d_in      (flags_d),
		.mask_d_in       (interrupt_enable_mask_d),
		.active_low_d_in (active_low_d),
		.irq_out         (irq_out)
	);

	// ======================================================================
	// Amplifier cut-off
	// The cut-off holds until the transmit state is left, so a relock mid-frame
	// cannot switch the amplifier back on with a corrupted carrier.
	always_comb begin
		pa_state_d = pa_state_q;
		case (pa_state_q)
			radio_interrupt_pkg::PA_IDLE: begin
				if (tx_busy_in && pll_unlock_in) begin
					pa_state_d = radio_interrupt_pkg::PA_CUT;
				end else if (tx_busy_in) begin
					pa_state_d = radio_interrupt_pkg::PA_TX;
				end
			end
			radio_interrupt_pkg::PA_TX: begin
				if (tx_busy_in && pll_unlock_in) begin
					pa_state_d = radio_interrupt_pkg::PA_CUT;
				end else if (!tx_busy_in) begin
					pa_state_d = radio_interrupt_pkg::PA_IDLE;
				end
			end
			radio_interrupt_pkg::PA_CUT: begin
				if (!tx_busy_in) begin
					pa_state_d = radio_interrupt_pkg::PA_IDLE;
				end
			end
			default: begin
				pa_state_d = radio_interrupt_pkg::PA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pa_state_q <= radio_interrupt_pkg::PA_IDLE;
			pa_off_q   <= 1'b0;
		end else begin
			pa_state_q <= pa_state_d;
			pa_off_q   <= (pa_state_d == radio_interrupt_pkg::PA_CUT);
		end
	end

	assign reg_rdata_out  = reg_rdata_q;
	assign reg_rvalid_out = reg_rvalid_q;
	assign pa_off_out     = pa_off_q;

endmodule

`default_nettype wire

// ### radio_interrupt_params.svh
`ifndef RADIO_INTERRUPT_PARAMS_SVH
`define RADIO_INTERRUPT_PARAMS_SVH

// ==========================================================================
// Register offsets
`define ADDR_TRANSCEIVER_CONTROL_ONE 8'h04
`define ADDR_INTERRUPT_ENABLE_MASK   8'h0E
`define ADDR_INTERRUPT_FLAGS         8'h0F

// ==========================================================================
// Reset values and fixed constants
`define RESET_INTERRUPT_ENABLE_MASK  8'h00
`define RESET_INTERRUPT_FLAGS        8'h00
`define RESET_CONTROL_ONE            8'h00
`define READ_UNMAPPED_VALUE          8'h00
`define ALL_EVENTS_RECORDED          8'hFF

// ==========================================================================
// Control register field positions
`define CTRL_POLARITY_BIT            0
`define CTRL_VISIBILITY_BIT          1

// ==========================================================================
// Flag bit positions
`define FLAG_LOCK                    0
`define FLAG_UNLOCK                  1
`define FLAG_RECEPTION_START         2
`define FLAG_FRAME_COMPLETE          3
`define FLAG_WAKE_OR_MEASURE         4
`define FLAG_ADDRESS_MATCH           5
`define FLAG_BUFFER_VIOLATION        6
`define FLAG_SUPPLY_LOW              7

`endif

// ### radio_interrupt_pkg.sv
`default_nettype none

package radio_interrupt_pkg;

	typedef logic [7:0] reg_byte_type;

	typedef enum logic [2:0] {
		PA_IDLE = 3'b001,
		PA_TX   = 3'b010,
		PA_CUT  = 3'b100
	} pa_state_type;

endpackage

`default_nettype wire

// ### event_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_interrupt_params.svh"

module event_flag_bank (
	input  wire logic                              clk_in,
	input  wire logic                              rst_n_in,
	input  wire logic                              clear_all_in,
	input  wire logic                              read_clear_in,
	input  wire radio_interrupt_pkg::reg_byte_type event_in,
	input  wire radio_interrupt_pkg::reg_byte_type record_in,
	output var  radio_interrupt_pkg::reg_byte_type flags_d_out,
	output var  radio_interrupt_pkg::reg_byte_type flags_q_out
);

	radio_interrupt_pkg::reg_byte_type flags_q;
	radio_interrupt_pkg::reg_byte_type flags_d;
	radio_interrupt_pkg::reg_byte_type recorded;

	// ======================================================================
	// Next flag value
	always_comb begin
		recorded = event_in & record_in;
		flags_d  = flags_q;
		if (read_clear_in) begin
			flags_d = `RESET_INTERRUPT_FLAGS;
		end
		// A lock and an unlock each wipe the other's stale flag.
		if (event_in[`FLAG_LOCK]) begin
			flags_d[`FLAG_UNLOCK] = 1'b0;
		end
		if (event_in[`FLAG_UNLOCK]) begin
			flags_d[`FLAG_LOCK] = 1'b0;
		end
		// Setting comes after the read clear so a new event survives a clearing read.
		flags_d = flags_d | recorded;
		if (clear_all_in) begin
			flags_d = `RESET_INTERRUPT_FLAGS;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			flags_q <= `RESET_INTERRUPT_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign flags_d_out = flags_d;
	assign flags_q_out = flags_q;

endmodule

`default_nettype wire

// ### irq_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_interrupt_params.svh"

module irq_pin_driver (
	input  wire logic                              clk_in,
	input  wire logic                              rst_n_in,
	input  wire radio_interrupt_pkg::reg_byte_type flags_d_in,
	input  wire radio_interrupt_pkg::reg_byte_type mask_d_in,
	input  wire logic                              active_low_d_in,
	output var  logic                              irq_out
);

	logic request;
	logic irq_q;

	// ======================================================================
	// Pin level
	// Fed from next-state values so the pin moves on the same edge as the flags.
	always_comb begin
		request = |(flags_d_in & mask_d_in);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= request ^ active_low_d_in;
		end
	end

	assign irq_out = irq_q;

endmodule

`default_nettype wire

// ### radio_interrupt_logic_properties.sv
`timescale 1ns/1ps
`default_nettype none
module radio_interrupt_checker (
	input wire logic       clk_in,
	input wire logic       rst_n_in,
	input wire logic       reg_clear_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       reg_rvalid_out,
	input wire logic       pll_unlock_in,
	input wire logic       tx_busy_in,
	input wire logic       irq_out,
	input wire logic       pa_off_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ==========
	// Register port
	sequence s_mask_wr;
		reg_wr_in && !reg_rd_in && !reg_clear_in && reg_addr_in == 8'h0E;
	endsequence
	sequence s_mask_rd;
		reg_rd_in && !reg_wr_in && !reg_clear_in && reg_addr_in == 8'h0E;
	endsequence
	a_read_answers: assert property (reg_rd_in |=> reg_rvalid_out) else $error("no read answer");
	a_rvalid_single: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray read valid");
	a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out)) else $error("read data moved");
	a_unmapped_zero: assert property (reg_rd_in && reg_addr_in > 8'h0F |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_mask_readback: assert property (s_mask_wr ##1 !reg_wr_in ##1 s_mask_rd
		|=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("mask readback wrong");
	// ==========
	// Pin and amplifier
	a_clear_drops_pin: assert property (reg_clear_in |=> !irq_out) else $error("pin kept after clear");
	a_pa_cut_unlock: assert property (tx_busy_in && pll_unlock_in |=> pa_off_out)
		else $error("amplifier not cut");
	a_pa_release: assert property (!tx_busy_in ##1 !tx_busy_in |=> !pa_off_out)
		else $error("amplifier cut when idle");
	a_pa_no_spurious: assert property (!pa_off_out && !(tx_busy_in && pll_unlock_in) |=> !pa_off_out)
		else $error("amplifier cut without cause");
endmodule
bind radio_interrupt_logic radio_interrupt_checker u_chk (.clk_in, .rst_n_in, .reg_clear_in, .reg_addr_in,
	.reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .pll_unlock_in, .tx_busy_in,
	.irq_out, .pa_off_out);
`default_nettype wire

// ### radio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module radio_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output var  logic [7:0] addr_out,
	output var  logic       wr_out,
	output var  logic       rd_out,
	output var  logic [7:0] wdata_out
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	// Released write data is inverted so a stale value is never mistaken for a held one.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		wdata_out = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		q = rdata_in;
	endtask
endmodule
`default_nettype wire

// ### radio_interrupt_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module radio_interrupt_logic_tb;
	logic       clk_in;
	logic       rst_n_in;
	logic       reg_clear_in;
	logic [7:0] reg_addr_in;
	logic       reg_wr_in;
	logic       reg_rd_in;
	logic [7:0] reg_wdata_in;
	logic [7:0] reg_rdata_out;
	logic       reg_rvalid_out;
	logic [9:0] ev;
	logic       tx_busy_in;
	logic       irq_out;
	logic       pa_off_out;
	logic [7:0] d;
	int         fail_count;
	int         checked;
	radio_interrupt_logic u_dut (.clk_in, .rst_n_in, .reg_clear_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
		.reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .supply_low_event_in(ev[7]),
		.buffer_access_violation_in(ev[6]), .address_match_event_in(ev[5]), .wake_complete_in(ev[4]),
		.channel_measurement_done_in(ev[9]), .frame_complete_rx_in(ev[3]), .frame_complete_tx_in(ev[8]),
		.reception_start_in(ev[2]), .pll_unlock_in(ev[1]), .pll_lock_in(ev[0]), .tx_busy_in, .irq_out,
		.pa_off_out);
	radio_host_model u_host (.clk_in, .rdata_in(reg_rdata_out), .addr_out(reg_addr_in),
		.wr_out(reg_wr_in), .rd_out(reg_rd_in), .wdata_out(reg_wdata_in));
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// ==========
	// Shared tasks
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic pulse(input int k);
		@(negedge clk_in);
		ev[k] = 1'b1;
		@(negedge clk_in);
		ev[k] = 1'b0;
	endtask
	task automatic end_sim();
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ==========
	// Scenarios
	task automatic t_reset();
		u_host.rd(8'h0E, d); chk(d, 8'h00);
		chk(reg_rvalid_out, 1'b1);
		u_host.rd(8'h04, d); chk(d, 8'h00);
		chk(irq_out, 1'b0);
		u_host.wr(8'h0E, 8'hA5); u_host.rd(8'h0E, d); chk(d, 8'hA5);
		u_host.wr(8'h0F, 8'hFF); u_host.rd(8'h10, d); chk(d, 8'h00);
	endtask
	task automatic t_flags();
		int b;
		for (int k = 0; k < 10; k++) begin
			b = (k < 8) ? k : (k == 8 ? 3 : 4);
			u_host.wr(8'h0E, 8'h01 << b);
			u_host.rd(8'h0F, d);
			pulse(k);
			repeat (2) @(negedge clk_in);
			chk(irq_out, 1'b1);
			u_host.rd(8'h0F, d); chk(d, 8'h01 << b);
			chk(irq_out, 1'b0);
			u_host.rd(8'h0F, d); chk(d, 8'h00);
		end
	endtask
	task automatic t_cross();
		u_host.wr(8'h0E, 8'h03);
		pulse(0); pulse(1);
		u_host.rd(8'h0F, d); chk(d, 8'h02);
		pulse(1); pulse(0);
		u_host.rd(8'h0F, d); chk(d, 8'h01);
	endtask
	task automatic t_masked();
		u_host.wr(8'h0E, 8'h00);
		pulse(7); chk(irq_out, 1'b0);
		u_host.rd(8'h0F, d); chk(d, 8'h00);
		u_host.wr(8'h04, 8'h02); u_host.rd(8'h0F, d);
		pulse(7); chk(irq_out, 1'b0);
		u_host.rd(8'h0F, d); chk(d, 8'h80);
		u_host.wr(8'h04, 8'h00);
	endtask
	task automatic t_polarity();
		u_host.wr(8'h04, 8'h01); u_host.wr(8'h0E, 8'h01); u_host.rd(8'h0F, d);
		chk(irq_out, 1'b1);
		pulse(0); chk(irq_out, 1'b0);
		u_host.rd(8'h0F, d); chk(d, 8'h01);
		chk(irq_out, 1'b1);
		u_host.wr(8'h04, 8'h00); chk(irq_out, 1'b0);
	endtask
	task automatic t_pa();
		@(negedge clk_in) tx_busy_in = 1'b1;
		pulse(1); chk(pa_off_out, 1'b1);
		@(negedge clk_in) tx_busy_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk(pa_off_out, 1'b0);
		pulse(1); chk(pa_off_out, 1'b0);
	endtask
	task automatic t_race();
		u_host.wr(8'h0E, 8'h01); u_host.rd(8'h0F, d);
		fork
			u_host.rd(8'h0F, d);
			pulse(0);
		join
		chk(d, 8'h00);
		chk(irq_out, 1'b1);
		u_host.rd(8'h0F, d); chk(d, 8'h01);
	endtask
	task automatic t_clear();
		u_host.wr(8'h0E, 8'hFF); pulse(7);
		chk(irq_out, 1'b1);
		@(negedge clk_in) reg_clear_in = 1'b1;
		@(negedge clk_in) reg_clear_in = 1'b0;
		chk(irq_out, 1'b0);
		u_host.rd(8'h0F, d); chk(d, 8'h00);
		u_host.rd(8'h0E, d); chk(d, 8'h00);
	endtask
	// ==========
	// Main sequence
	initial begin
		fail_count = 0;
		checked = 0;
		rst_n_in = 1'b0;
		reg_clear_in = 1'b0;
		ev = 10'h000;
		tx_busy_in = 1'b0;
		repeat (3) @(negedge clk_in);
		rst_n_in = 1'b1;
		t_reset(); t_flags(); t_cross(); t_masked();
		t_polarity(); t_pa(); t_race(); t_clear();
		end_sim();
	end
	// The whole run needs well under two thousand cycles, so this limit only trips on a hang.
	initial begin
		#50000;
		fail_count++;
		end_sim();
	end
endmodule
`default_nettype wire
